//--- core/flash_reset_control.sv
// Functional notes
// - Power-on reset lasts the power-up delay after supply becomes good.
// - Hardware reset pin is ignored while power-on reset runs.
// - Fourth pulse end starts reset: abort, tristate, ignore, then standby.
// - Signalling reset is recognised from every internal state except power-on reset.
// - Soft reset runs at chip-select rise and takes the soft reset time.
// - Soft reset needs the arm command directly before; others disarm.
// - During soft reset with matching config only status reads allowed.
// - Soft reset works only while the hardware reset pin is high; a low pin gives hardware reset.
// - Soft reset reloads volatile state but keeps lock and password state.
// - Hard resets ignore inputs, tristate outputs, reload status and config.
// - Hard resets load locks from protection config bits 2:1, 4, 2 and 0.
// - Every reset clears the diagnostic and error count registers.
// - Resets abort program and erase; hard resets also abort reads.
// - Boot config reloads on hard resets, unchanged by soft reset.
// - Every reset restores volatile protection, keeps non-volatile protection.
`timescale 1ns/1ps
`default_nettype none
module flash_reset_control (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  sclk,
  input  wire logic                  csN,
  input  wire logic                  dq0,
  input  wire logic                  resetPinN,
  input  wire logic                  vccOk,
  input  wire logic [frc_pkg::REG_W-1:0]  nvStatus,
  input  wire logic [frc_pkg::REG_W-1:0]  nvConfig,
  input  wire logic [frc_pkg::REG_W-1:0]  nvBootCfg,
  input  wire logic [frc_pkg::PROT_W-1:0] protCfg,
  input  wire logic                  cfgWrEn,
  input  wire logic [frc_pkg::REG_W-1:0]  cfgWrData,
  input  wire logic                  eccErr,
  input  wire logic                  progActive,
  input  wire logic                  eraseActive,
  input  wire logic                  readActive,
  output frc_pkg::frc_state_t        state_q,
  output logic                       busy_q,
  output logic                       ignoreIn_q,
  output logic                       outEnN_q,
  output logic                       statusRdOnly_q,
  output logic                       armed_q,
  output logic [frc_pkg::REG_W-1:0]  status_q,
  output logic [frc_pkg::REG_W-1:0]  config_q,
  output logic [frc_pkg::REG_W-1:0]  bootCfg_q,
  output logic                       lockPersist_q,
  output logic                       dynAccess_q,
  output logic                       pwdLock_q,
  output logic [frc_pkg::REG_W-1:0]  dynLock_q,
  output logic [frc_pkg::REG_W-1:0]  eccCount_q,
  output logic                       abortProg_q,
  output logic                       abortErase_q,
  output logic                       abortRead_q
);
  import frc_pkg::*;

  // Pin synchronisers: {vccOk, resetPinN, csN, dq0}.
  logic [3:0] pinMeta_q;
  logic [3:0] pinSync_q;
  // Link toggles: {opTgl, bitTgl}.
  logic [1:0] tglMeta_q;
  logic [1:0] tglSync_q;
  logic [1:0] tglDly_q;
  logic [1:0] csDly_q;
  logic [7:0] opLat_q;
  logic       opValid_q;
  logic [TIMER_W-1:0] timer_q;
  logic       cfgMatch_q;
  logic       sigFire;

  frc_link_if lnk ();

  frc_cmd_shift u_shift (
    .sclk   (sclk),
    .arst_n (arst_n),
    .csN    (csN),
    .dq0    (dq0),
    .lnk    (lnk.src)
  );

  wire vccS    = pinSync_q[3];
  wire pinHigh = pinSync_q[2];
  wire csS     = pinSync_q[1];
  wire dqS     = pinSync_q[0];
  wire opEdge  = tglSync_q[1] ^ tglDly_q[1];
  wire bitEdge = tglSync_q[0] ^ tglDly_q[0];
  // Chip-select rise is seen one cycle after csS so the opcode toggle,
  // which left the link earlier, has surely crossed first.
  wire csRise  = csDly_q[0] & ~csDly_q[1];
  wire hardRst = (state_q == FRC_POR) || (state_q == FRC_HWRST) ||
                 (state_q == FRC_HWREC) || (state_q == FRC_SIGRST);
  wire inReset = (state_q != FRC_READY);

  wire softGo  = (state_q == FRC_READY) && csRise && opValid_q &&
                 (opLat_q == OP_SOFT_RST) && armed_q;

  frc_sig_detect u_sig (
    .clk     (clk),
    .arst_n  (arst_n),
    .csLow   (~csS),
    .dq      (dqS),
    .clkEdge (bitEdge),
    .fire_q  (sigFire)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_q <= 4'h6;
      pinSync_q <= 4'h6;
      tglMeta_q <= 2'h0;
      tglSync_q <= 2'h0;
      tglDly_q  <= 2'h0;
      csDly_q   <= 2'h3;
    end else begin
      pinMeta_q <= {vccOk, resetPinN, csN, dq0};
      pinSync_q <= pinMeta_q;
      tglMeta_q <= {lnk.opTgl, lnk.bitTgl};
      tglSync_q <= tglMeta_q;
      tglDly_q  <= tglSync_q;
      csDly_q   <= {csDly_q[0], csS};
    end
  end

  // Opcode is stable on the link side once its toggle is seen here.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opLat_q   <= 8'h00;
      opValid_q <= 1'b0;
    end else if (csRise) begin
      opValid_q <= 1'b0;
    end else if (opEdge) begin
      opLat_q   <= lnk.opByte;
      opValid_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'b0;
    end else if (state_q != FRC_READY) begin
      armed_q <= 1'b0;
    end else if (csRise) begin
      armed_q <= opValid_q && (opLat_q == OP_SOFT_ARM);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= FRC_POR;
      timer_q <= TIMER_W'(PU_CYC);
    end else if (!vccS) begin
      state_q <= FRC_POR;
      timer_q <= TIMER_W'(PU_CYC);
    end else if (state_q == FRC_POR) begin
      if (timer_q != '0) begin
        timer_q <= timer_q - TIMER_W'(1);
      end else if (!pinHigh) begin
        state_q <= FRC_HWRST;
      end else begin
        state_q <= FRC_READY;
      end
    end else if (!pinHigh) begin
      state_q <= FRC_HWRST;
    end else if (sigFire) begin
      state_q <= FRC_SIGRST;
      timer_q <= TIMER_W'(SIG_CYC);
    end else begin
      case (state_q)
        FRC_HWRST: begin
          state_q <= FRC_HWREC;
          timer_q <= TIMER_W'(RS_CYC);
        end
        FRC_HWREC, FRC_SIGRST, FRC_SOFTRST: begin
          if (timer_q != '0) begin
            timer_q <= timer_q - TIMER_W'(1);
          end else begin
            state_q <= FRC_READY;
          end
        end
        FRC_READY: begin
          if (softGo) begin
            state_q <= FRC_SOFTRST;
            timer_q <= TIMER_W'(SR_CYC);
          end
        end
        default: begin
          state_q <= FRC_POR;
          timer_q <= TIMER_W'(PU_CYC);
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q   <= DIAG_RST;
      config_q   <= DIAG_RST;
      cfgMatch_q <= 1'b0;
    end else if (inReset) begin
      status_q <= nvStatus;
      config_q <= nvConfig;
      if (state_q != FRC_SOFTRST) begin
        cfgMatch_q <= 1'b1;
      end
    end else begin
      if (softGo) begin
        cfgMatch_q <= (config_q == nvConfig);
      end
      if (cfgWrEn) begin
        config_q <= cfgWrData;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bootCfg_q <= DIAG_RST;
    end else if (hardRst) begin
      bootCfg_q <= nvBootCfg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lockPersist_q <= 1'b1;
      dynAccess_q   <= 1'b0;
      pwdLock_q     <= 1'b1;
    end else if (hardRst) begin
      lockPersist_q <= ~(protCfg[PROT_PWD_BIT] & protCfg[PROT_PERS_BIT]);
      dynAccess_q   <= protCfg[PROT_DYN_BIT];
      pwdLock_q     <= ~protCfg[PROT_PWD_BIT] & protCfg[PROT_RDP_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dynLock_q <= DYN_LOCK_RST;
    end else if (inReset) begin
      dynLock_q <= DYN_LOCK_RST;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eccCount_q <= DIAG_RST;
    end else if (inReset) begin
      eccCount_q <= DIAG_RST;
    end else if (eccErr && eccCount_q != 8'hFF) begin
      eccCount_q <= eccCount_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q         <= 1'b1;
      ignoreIn_q     <= 1'b1;
      outEnN_q       <= 1'b1;
      statusRdOnly_q <= 1'b0;
      abortProg_q    <= 1'b0;
      abortErase_q   <= 1'b0;
      abortRead_q    <= 1'b0;
    end else begin
      busy_q         <= inReset;
      ignoreIn_q     <= hardRst;
      outEnN_q       <= hardRst;
      statusRdOnly_q <= (state_q == FRC_SOFTRST) && cfgMatch_q;
      abortProg_q    <= inReset && progActive;
      abortErase_q   <= inReset && eraseActive;
      abortRead_q    <= hardRst && readActive;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_por_hold:
    assert property ((state_q == FRC_POR && timer_q != '0)
                     |=> state_q == FRC_POR)
    else $error("Power-on reset ended before its delay.");

  a_por_pin_ignore:
    assert property ((state_q == FRC_POR && vccS && !pinHigh &&
                      timer_q != '0) |=> state_q == FRC_POR)
    else $error("Reset pin acted during power-on reset.");

  a_sig_entry:
    assert property ((sigFire && vccS && pinHigh && state_q != FRC_POR)
                     |=> state_q == FRC_SIGRST && timer_q == SIG_CYC)
    else $error("Signalling reset did not start.");

  a_soft_entry:
    assert property ((softGo && vccS && pinHigh && !sigFire)
                     |=> state_q == FRC_SOFTRST && timer_q == SR_CYC)
    else $error("Soft reset did not start.");

  a_soft_needs_arm:
    assert property ((state_q == FRC_READY && !armed_q)
                     |=> state_q != FRC_SOFTRST)
    else $error("Soft reset ran without arm.");

  a_soft_status_only:
    assert property ((state_q == FRC_SOFTRST && cfgMatch_q)
                     |=> statusRdOnly_q)
    else $error("Status-only flag missing in soft reset.");

  a_soft_keeps_prot:
    assert property ((state_q == FRC_SOFTRST && $past(state_q) != FRC_POR)
                     |=> $stable(lockPersist_q) && $stable(pwdLock_q)
                         && $stable(bootCfg_q))
    else $error("Soft reset changed kept state.");

  a_hard_tristate:
    assert property (hardRst |=> outEnN_q && ignoreIn_q
                                 && status_q == $past(nvStatus))
    else $error("Hard reset left outputs driven or status stale.");

  a_prot_load:
    assert property (hardRst |=> dynAccess_q == $past(protCfg[PROT_DYN_BIT]))
    else $error("Dynamic lock access not loaded.");

  a_diag_clear:
    assert property (inReset |=> eccCount_q == DIAG_RST)
    else $error("Error count not cleared in reset.");

  a_abort_prog:
    assert property ((inReset && progActive) |=> abortProg_q)
    else $error("Program not aborted by reset.");

  a_boot_reload:
    assert property (hardRst |=> bootCfg_q == $past(nvBootCfg))
    else $error("Boot config not reloaded.");

  a_dyn_default:
    assert property (inReset |=> dynLock_q == DYN_LOCK_RST)
    else $error("Volatile protection not defaulted.");

  c_por_done: cover property (state_q == FRC_POR ##1 state_q == FRC_READY);
  c_soft_rst: cover property (state_q == FRC_READY ##1
                              state_q == FRC_SOFTRST);
  c_sig_rst:  cover property (state_q == FRC_READY ##1
                              state_q == FRC_SIGRST);
  c_hw_rec:   cover property (state_q == FRC_HWREC ##1
                              state_q == FRC_READY);

endmodule
`default_nettype wire

//--- core/frc_pkg.sv
package frc_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // Pin timings in microseconds; cycle counts round least times up.
  localparam int PU_TIME_US  = 300;
  localparam int RS_TIME_US  = 50;
  localparam int SIG_TIME_US = 100;
  localparam int SR_TIME_US  = 100;
  localparam int PU_CYC  = (PU_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int RS_CYC  = (RS_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int SIG_CYC = (SIG_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int SR_CYC  = (SR_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;

  localparam int SIG_PULSES = 4;
  localparam int PCNT_W     = 3;

  localparam logic [7:0] OP_SOFT_ARM = 8'h66;
  localparam logic [7:0] OP_SOFT_RST = 8'h99;

  // Positions inside the protection configuration word.
  localparam int PROT_W        = 5;
  localparam int PROT_DYN_BIT  = 4;
  localparam int PROT_PWD_BIT  = 2;
  localparam int PROT_PERS_BIT = 1;
  localparam int PROT_RDP_BIT  = 0;

  localparam int REG_W = 8;
  localparam logic [7:0] DYN_LOCK_RST = 8'hFF;
  localparam logic [7:0] DIAG_RST     = 8'h00;

  typedef enum logic [2:0] {
    FRC_POR,
    FRC_HWRST,
    FRC_HWREC,
    FRC_SIGRST,
    FRC_SOFTRST,
    FRC_READY
  } frc_state_t;

endpackage

//--- core/frc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface frc_link_if;
  logic       opTgl;
  logic [7:0] opByte;
  logic       bitTgl;
  modport src (output opTgl, output opByte, output bitTgl);
  modport dst (input opTgl, input opByte, input bitTgl);
endinterface
`default_nettype wire

//--- core/frc_cmd_shift.sv
`timescale 1ns/1ps
`default_nettype none
module frc_cmd_shift (
  input  wire logic sclk,
  input  wire logic arst_n,
  input  wire logic csN,
  input  wire logic dq0,
  frc_link_if.src   lnk
);
  import frc_pkg::*;

  logic [2:0] bitCnt_q;
  logic [6:0] shift_q;
  logic       gotOp_q;
  wire        linkClr_n = arst_n & ~csN;

  // The link clock stops outside frames, so a high chip select clears
  // the shifter asynchronously instead of waiting for an edge.
  always_ff @(posedge sclk or negedge linkClr_n) begin
    if (!linkClr_n) begin
      bitCnt_q <= 3'h0;
      shift_q  <= 7'h00;
      gotOp_q  <= 1'b0;
    end else begin
      bitCnt_q <= bitCnt_q + 3'h1;
      shift_q  <= {shift_q[5:0], dq0};
      if (bitCnt_q == 3'h7) begin
        gotOp_q <= 1'b1;
      end
    end
  end

  // Only the first byte of a frame is the opcode.
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.opByte <= 8'h00;
      lnk.opTgl  <= 1'b0;
    end else if (!csN && !gotOp_q && bitCnt_q == 3'h7) begin
      lnk.opByte <= {shift_q, dq0};
      lnk.opTgl  <= ~lnk.opTgl;
    end
  end

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.bitTgl <= 1'b0;
    end else if (!csN) begin
      lnk.bitTgl <= ~lnk.bitTgl;
    end
  end

endmodule
`default_nettype wire

//--- core/frc_sig_detect.sv
`timescale 1ns/1ps
`default_nettype none
module frc_sig_detect (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic csLow,
  input  wire logic dq,
  input  wire logic clkEdge,
  output logic      fire_q
);
  import frc_pkg::*;

  localparam logic [PCNT_W-1:0] LAST = PCNT_W'(SIG_PULSES - 1);

  logic              csLowDly_q;
  logic              clkSeen_q;
  logic              dqHeld_q;
  logic              lastDq_q;
  logic [PCNT_W-1:0] cnt_q;
  wire               pulseEnd = csLowDly_q & ~csLow;
  wire               alt      = (cnt_q == '0) | (dqHeld_q != lastDq_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      csLowDly_q <= 1'b0;
      dqHeld_q   <= 1'b0;
    end else begin
      csLowDly_q <= csLow;
      if (csLow) begin
        dqHeld_q <= dq;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clkSeen_q <= 1'b0;
    end else if (csLow && clkEdge) begin
      clkSeen_q <= 1'b1;
    end else if (!csLow && !csLowDly_q) begin
      clkSeen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q    <= '0;
      lastDq_q <= 1'b0;
      fire_q   <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      if (pulseEnd) begin
        lastDq_q <= dqHeld_q;
        if (clkSeen_q) begin
          cnt_q <= '0;
        end else if (!alt) begin
          cnt_q <= PCNT_W'(1);
        end else if (cnt_q == LAST) begin
          cnt_q  <= '0;
          fire_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + PCNT_W'(1);
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_clk_restart:
    assert property ((pulseEnd && clkSeen_q) |=> cnt_q == '0 && !fire_q)
    else $error("Pulse with clock activity did not restart the count.");

  a_fire_fourth:
    assert property (fire_q |-> $past(cnt_q) == LAST && $past(pulseEnd))
    else $error("Signalling reset fired without four pulses.");

  c_fire: cover property (fire_q);

endmodule
`default_nettype wire

//--- testbench/frc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module frc_host_model (
  output logic sclk,
  output logic csN,
  output logic dq0
);
  logic lclk = 1'b0;

  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    dq0 = 1'b0;
  end

  always #16 lclk = ~lclk;

  // A released data line shows the inverse, so a stale level never matches.
  task automatic idle(input int n);
    csN = 1'b1;
    dq0 = ~dq0;
    repeat (n) @(negedge lclk);
  endtask

  // The serial clock runs only inside a frame.
  task automatic sendByte(input logic [7:0] b);
    int i;
    @(negedge lclk);
    csN = 1'b0;
    for (i = 7; i >= 0; i--) begin
      dq0 = b[i];
      @(posedge lclk) sclk = 1'b1;
      @(negedge lclk) sclk = 1'b0;
    end
    // Hold the frame open with the clock still, so that the core sees the
    // clock activity before it sees chip select rise and never counts a
    // command frame as a signalling pulse.
    repeat (8) @(negedge lclk);
    idle(16);
  endtask

  task automatic sigPulses(input logic brk);
    int i;
    logic lvl;
    lvl = 1'b0;
    for (i = 0; i < 4; i++) begin
      @(negedge lclk);
      csN = 1'b0;
      dq0 = lvl;
      repeat (16) @(negedge lclk);
      idle(16);
      if (!(brk && i == 1)) begin
        lvl = ~lvl;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import frc_pkg::*;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              sclk;
  logic              csN;
  logic              dq0;
  logic              resetPinN = 1'b1;
  logic              vccOk = 1'b0;
  logic [REG_W-1:0]  nvStatus = 8'h5A;
  logic [REG_W-1:0]  nvConfig = 8'h3C;
  logic [REG_W-1:0]  nvBootCfg = 8'h81;
  logic [PROT_W-1:0] protCfg = 5'h07;
  logic              cfgWrEn = 1'b0;
  logic [REG_W-1:0]  cfgWrData = 8'h00;
  logic              eccErr = 1'b0;
  logic              progActive = 1'b0;
  logic              eraseActive = 1'b0;
  logic              readActive = 1'b0;
  frc_state_t        state_q;
  logic              busy_q;
  logic              ignoreIn_q;
  logic              outEnN_q;
  logic              statusRdOnly_q;
  logic              armed_q;
  logic [REG_W-1:0]  status_q;
  logic [REG_W-1:0]  config_q;
  logic [REG_W-1:0]  bootCfg_q;
  logic [REG_W-1:0]  dynLock_q;
  logic [REG_W-1:0]  eccCount_q;
  logic              lockPersist_q;
  logic              dynAccess_q;
  logic              pwdLock_q;
  logic              abortProg_q;
  logic              abortErase_q;
  logic              abortRead_q;
  int                errors = 0;
  int                compares = 0;
  int                cyc = 0;

  always #50 clk = ~clk;

  frc_host_model frc_host_model_inst (.sclk(sclk), .csN(csN), .dq0(dq0));

  flash_reset_control flash_reset_control_inst (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .csN(csN), .dq0(dq0),
    .resetPinN(resetPinN), .vccOk(vccOk), .nvStatus(nvStatus),
    .nvConfig(nvConfig), .nvBootCfg(nvBootCfg), .protCfg(protCfg),
    .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .eccErr(eccErr),
    .progActive(progActive), .eraseActive(eraseActive),
    .readActive(readActive), .state_q(state_q), .busy_q(busy_q),
    .ignoreIn_q(ignoreIn_q), .outEnN_q(outEnN_q),
    .statusRdOnly_q(statusRdOnly_q), .armed_q(armed_q),
    .status_q(status_q), .config_q(config_q), .bootCfg_q(bootCfg_q),
    .lockPersist_q(lockPersist_q), .dynAccess_q(dynAccess_q),
    .pwdLock_q(pwdLock_q), .dynLock_q(dynLock_q),
    .eccCount_q(eccCount_q), .abortProg_q(abortProg_q),
    .abortErase_q(abortErase_q), .abortRead_q(abortRead_q)
  );

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkBit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chkSt(input frc_state_t e);
    compares++;
    if (state_q !== e) begin
      errors++;
      $display("Error state expected %0d seen %0d", e, state_q);
    end
  endtask

  task automatic waitSt(input frc_state_t s, input int lim);
    int i;
    for (i = 0; i < lim && state_q !== s; i++) begin
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
    chkSt(s);
  endtask

  task automatic chkProt(input logic [PROT_W-1:0] p);
    chkBit("lockPersist", ~(p[PROT_PWD_BIT] & p[PROT_PERS_BIT]),
           lockPersist_q);
    chkBit("dynAccess", p[PROT_DYN_BIT], dynAccess_q);
    chkBit("pwdLock", ~p[PROT_PWD_BIT] & p[PROT_RDP_BIT], pwdLock_q);
  endtask

  task automatic tPor();
    vccOk = 1'b1;
    resetPinN = 1'b0;
    repeat (100) @(negedge clk);
    resetPinN = 1'b1;
    repeat (PU_CYC - 200) @(negedge clk);
    chkSt(FRC_POR);
    waitSt(FRC_READY, 400);
    chk8("status", nvStatus, status_q);
    chk8("config", nvConfig, config_q);
    chk8("bootCfg", nvBootCfg, bootCfg_q);
    chkProt(protCfg);
    chkBit("outEnN", 1'b0, outEnN_q);
  endtask

  task automatic tSoft();
    cfgWrData = 8'hA5;
    cfgWrEn = 1'b1;
    @(negedge clk);
    cfgWrEn = 1'b0;
    repeat (2) begin
      eccErr = 1'b1;
      @(negedge clk);
      eccErr = 1'b0;
      @(negedge clk);
    end
    chk8("eccCount", 8'h02, eccCount_q);
    chk8("config", 8'hA5, config_q);
    nvBootCfg = 8'h42;
    protCfg = 5'h10;
    frc_host_model_inst.sendByte(OP_SOFT_ARM);
    repeat (10) @(negedge clk);
    chkBit("armed", 1'b1, armed_q);
    progActive = 1'b1;
    eraseActive = 1'b1;
    readActive = 1'b1;
    frc_host_model_inst.sendByte(OP_SOFT_RST);
    waitSt(FRC_SOFTRST, 20);
    chkBit("abortProg", 1'b1, abortProg_q);
    chkBit("abortErase", 1'b1, abortErase_q);
    chkBit("abortRead", 1'b0, abortRead_q);
    chkBit("statusRdOnly", 1'b0, statusRdOnly_q);
    progActive = 1'b0;
    eraseActive = 1'b0;
    readActive = 1'b0;
    repeat (SR_CYC - 50) @(negedge clk);
    chkSt(FRC_SOFTRST);
    waitSt(FRC_READY, 100);
    chk8("config", nvConfig, config_q);
    chk8("bootCfg", 8'h81, bootCfg_q);
    chkProt(5'h07);
    chk8("eccCount", 8'h00, eccCount_q);
    chk8("dynLock", DYN_LOCK_RST, dynLock_q);
  endtask

  task automatic tDisarm();
    frc_host_model_inst.sendByte(OP_SOFT_ARM);
    frc_host_model_inst.sendByte(8'h05);
    frc_host_model_inst.sendByte(OP_SOFT_RST);
    repeat (20) @(negedge clk);
    chkSt(FRC_READY);
    chkBit("armed", 1'b0, armed_q);
    frc_host_model_inst.sendByte(OP_SOFT_ARM);
    frc_host_model_inst.sendByte(OP_SOFT_RST);
    waitSt(FRC_SOFTRST, 20);
    chkBit("statusRdOnly", 1'b1, statusRdOnly_q);
    frc_host_model_inst.sigPulses(1'b0);
    waitSt(FRC_SIGRST, 20);
    waitSt(FRC_READY, SIG_CYC + 100);
  endtask

  task automatic tSig();
    protCfg = 5'h01;
    nvBootCfg = 8'h24;
    readActive = 1'b1;
    progActive = 1'b1;
    frc_host_model_inst.sigPulses(1'b1);
    repeat (20) @(negedge clk);
    chkSt(FRC_READY);
    frc_host_model_inst.sigPulses(1'b0);
    waitSt(FRC_SIGRST, 20);
    chkBit("outEnN", 1'b1, outEnN_q);
    chkBit("ignoreIn", 1'b1, ignoreIn_q);
    chkBit("abortRead", 1'b1, abortRead_q);
    chkBit("abortProg", 1'b1, abortProg_q);
    readActive = 1'b0;
    progActive = 1'b0;
    repeat (SIG_CYC - 50) @(negedge clk);
    chkSt(FRC_SIGRST);
    waitSt(FRC_READY, 100);
    chk8("bootCfg", 8'h24, bootCfg_q);
    chkProt(5'h01);
  endtask

  task automatic tHw();
    resetPinN = 1'b0;
    waitSt(FRC_HWRST, 10);
    chkBit("outEnN", 1'b1, outEnN_q);
    resetPinN = 1'b1;
    waitSt(FRC_HWREC, 10);
    waitSt(FRC_READY, RS_CYC + 20);
    chk8("status", nvStatus, status_q);
  endtask

  // The ceiling leaves about three times the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    chkSt(FRC_POR);
    chk8("dynLock", DYN_LOCK_RST, dynLock_q);
    chkBit("busy", 1'b1, busy_q);
    @(negedge clk);
    arst_n = 1'b1;
    tPor();
    tSoft();
    tDisarm();
    tSig();
    tHw();
    results();
  end
endmodule
`default_nettype wire
